// ===== rtl/sync_slave_tx.sv
// Synchronous slave transmitter with an AHB-Lite register slave and a sticky interrupt.
// Assumes the external master drives the shift clock, idling low, and samples on its rising edge.
// Contract
// - Clocked-mode select set makes the unit run synchronously.
// - Clock source select clear makes the unit a slave using the external clock.
// - Transmit direction only while both receive enables are clear.
// - The whole unit is active only while serial port enable is set.
// - Slave transmission behaves like master transmission except during sleep.
// - In sleep with two words queued, the first moves to the shifter and shifts.
// - The second word waits in holding; transmit flag stays clear meanwhile.
// - After the first word shifts out, the second loads and the flag sets.
// - Flag in sleep wakes with peripheral and transmit enables; vectors with global enable.
// - The transmitter runs only when transmitter enable is set.
// - Writing the low byte into the holding register starts transmission.
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps

module sync_slave_tx
  import sync_tx_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // AHB-Lite slave.
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Serial pins.
  input wire logic SERIAL_CLOCK_PIN,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OE,
  // Interrupt and wake.
  output logic IRQ,
  output logic WAKE,
  output logic VECTOR
);

  typedef struct packed {
    logic ahb_write_pend;
    logic ahb_read_pend;
    logic [7:0] ahb_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic sync_mode;
    logic clock_source_master;
    logic nine_bit_transmit_enable;
    logic transmitter_enable;
    logic ninth_data_bit;
    logic serial_port_enable;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic [8:0] transmit_holding_reg;
    logic holding_full;
    logic [8:0] transmit_shift_reg;
    logic [3:0] bit_cnt;
    shift_state_t tx_state;
    logic [EVT_COUNT-1:0] irq_status;
    logic [EVT_COUNT-1:0] irq_mask;
    logic irq;
    logic sleep;
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic transmit_irq_enable;
    logic wake;
    logic vector;
    logic sck_meta;
    logic sck_sync;
    logic sck_prev;
    logic dt_out;
    logic dt_oe;
  } state_t;

  state_t s;
  state_t next_s;

  logic tx_active;
  logic transmit_irq_flag;
  logic sck_fall;
  logic load_shift;
  logic shift_last;
  logic [EVT_COUNT-1:0] events;
  logic [3:0] word_bits;

  // Transmit path is live only in synchronous slave transmit with the port and transmitter on.
  assign tx_active = s.serial_port_enable &&
                     s.sync_mode &&
                     !s.clock_source_master &&
                     !s.single_receive_enable && !s.continuous_receive_enable &&
                     s.transmitter_enable;

  // The flag is high while the transmit path is live and holding is empty.
  assign transmit_irq_flag = tx_active && !s.holding_full;

  // The pin clock has passed the synchroniser before this edge detector looks at it.
  assign sck_fall = s.sck_prev && !s.sck_sync;

  assign word_bits = s.nine_bit_transmit_enable ? BITS_NINE : BITS_EIGHT;

  // The shifter takes the held word as soon as it is free, asleep or not.
  assign load_shift = tx_active && s.holding_full &&
                      ((s.tx_state == ST_IDLE) || shift_last);

  assign shift_last = (s.tx_state == ST_SHIFT) && sck_fall &&
                      (s.bit_cnt == word_bits - 4'h1);

  always_comb begin
    events = '0;
    events[EVT_HOLD_EMPTIED] = load_shift;
    events[EVT_SHIFT_DONE] = shift_last;
  end

  function automatic logic [31:0] read_value(input state_t r, input logic flag);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (r.ahb_addr == OFF_TX_CTRL) begin
      v[TXC_SYNC] = r.sync_mode;
      v[TXC_CLOCK_SOURCE_MASTER] = r.clock_source_master;
      v[TXC_NINE_BIT] = r.nine_bit_transmit_enable;
      v[TXC_TRANSMITTER_ENABLE] = r.transmitter_enable;
      v[TXC_NINTH_DATA_BIT] = r.ninth_data_bit;
      v[TXC_SHIFT_EMPTY] = (r.tx_state == ST_IDLE);
      v[TXC_IRQ_FLAG] = flag;
    end else if (r.ahb_addr == OFF_RX_CTRL) begin
      v[RXC_SERIAL_PORT_ENABLE] = r.serial_port_enable;
      v[RXC_SINGLE_RECEIVE] = r.single_receive_enable;
      v[RXC_CONTINUOUS_RECEIVE] = r.continuous_receive_enable;
    end else if (r.ahb_addr == OFF_TX_HOLD) begin
      v[8:0] = r.transmit_holding_reg;
    end else if (r.ahb_addr == OFF_IRQ_STATUS) begin
      v[EVT_COUNT-1:0] = r.irq_status;
    end else if (r.ahb_addr == OFF_IRQ_MASK) begin
      v[EVT_COUNT-1:0] = r.irq_mask;
    end else if (r.ahb_addr == OFF_POWER) begin
      v[PWR_SLEEP] = r.sleep;
      v[PWR_GLOBAL_IRQ] = r.global_irq_enable;
      v[PWR_PERIPHERAL_IRQ] = r.peripheral_irq_enable;
      v[PWR_TRANSMIT_IRQ] = r.transmit_irq_enable;
    end
    return v;
  endfunction

  always_comb begin
    next_s = s;

    // Two-flop synchroniser on the external shift clock.
    next_s.sck_meta = SERIAL_CLOCK_PIN;
    next_s.sck_sync = s.sck_meta;
    next_s.sck_prev = s.sck_sync;

    // Bus: accept an address phase, reads take one wait state.
    next_s.ahb_write_pend = 1'b0;
    next_s.ahb_read_pend = 1'b0;
    next_s.hreadyout = 1'b1;
    if (s.ahb_read_pend) begin
      next_s.hrdata = read_value(s, transmit_irq_flag);
    end
    if (HSEL && HREADY && HTRANS[1]) begin
      next_s.ahb_addr = HADDR[7:0];
      next_s.ahb_write_pend = HWRITE;
      next_s.ahb_read_pend = !HWRITE;
      next_s.hreadyout = HWRITE;
    end

    // Register writes land at the end of the data phase.
    if (s.ahb_write_pend) begin
      if (s.ahb_addr == OFF_TX_CTRL) begin
        next_s.sync_mode = HWDATA[TXC_SYNC];
        next_s.clock_source_master = HWDATA[TXC_CLOCK_SOURCE_MASTER];
        next_s.nine_bit_transmit_enable = HWDATA[TXC_NINE_BIT];
        next_s.transmitter_enable = HWDATA[TXC_TRANSMITTER_ENABLE];
        next_s.ninth_data_bit = HWDATA[TXC_NINTH_DATA_BIT];
      end else if (s.ahb_addr == OFF_RX_CTRL) begin
        next_s.serial_port_enable = HWDATA[RXC_SERIAL_PORT_ENABLE];
        next_s.single_receive_enable = HWDATA[RXC_SINGLE_RECEIVE];
        next_s.continuous_receive_enable = HWDATA[RXC_CONTINUOUS_RECEIVE];
      end else if (s.ahb_addr == OFF_TX_HOLD) begin
        // The ninth bit is taken from the control field already written.
        next_s.transmit_holding_reg = {s.ninth_data_bit, HWDATA[7:0]};
        next_s.holding_full = 1'b1;
      end else if (s.ahb_addr == OFF_IRQ_STATUS) begin
        next_s.irq_status = s.irq_status & ~HWDATA[EVT_COUNT-1:0];
      end else if (s.ahb_addr == OFF_IRQ_MASK) begin
        next_s.irq_mask = HWDATA[EVT_COUNT-1:0];
      end else if (s.ahb_addr == OFF_POWER) begin
        next_s.sleep = HWDATA[PWR_SLEEP];
        next_s.global_irq_enable = HWDATA[PWR_GLOBAL_IRQ];
        next_s.peripheral_irq_enable = HWDATA[PWR_PERIPHERAL_IRQ];
        next_s.transmit_irq_enable = HWDATA[PWR_TRANSMIT_IRQ];
      end
    end

    // Shift engine: the same sequence runs whether or not the device sleeps.
    case (s.tx_state)
      ST_IDLE: begin
        next_s.bit_cnt = 4'h0;
      end
      ST_SHIFT: begin
        if (sck_fall) begin
          next_s.transmit_shift_reg = {1'b1, s.transmit_shift_reg[8:1]};
          next_s.bit_cnt = s.bit_cnt + 4'h1;
        end
        if (shift_last) begin
          next_s.tx_state = ST_IDLE;
          next_s.bit_cnt = 4'h0;
        end
      end
      default: begin
        next_s.tx_state = ST_IDLE;
      end
    endcase

    // A held word moves into the shifter and frees holding for the next write.
    if (load_shift) begin
      next_s.transmit_shift_reg = s.transmit_holding_reg;
      next_s.tx_state = ST_SHIFT;
      next_s.bit_cnt = 4'h0;
      if (!(s.ahb_write_pend && s.ahb_addr == OFF_TX_HOLD)) begin
        next_s.holding_full = 1'b0;
      end
    end

    // Dropping the transmitter aborts the word in the shifter.
    if (!tx_active) begin
      next_s.tx_state = ST_IDLE;
      next_s.bit_cnt = 4'h0;
    end

    // Clearing the serial port enable empties holding and resets the shifter.
    if (!s.serial_port_enable) begin
      next_s.holding_full = 1'b0;
      next_s.transmit_shift_reg = 9'h1ff;
    end

    // Data pin follows the low bit of the shifter, idle high while driven.
    next_s.dt_oe = next_s.serial_port_enable && next_s.sync_mode &&
                   !next_s.clock_source_master && !next_s.single_receive_enable &&
                   !next_s.continuous_receive_enable && next_s.transmitter_enable;
    next_s.dt_out = (next_s.tx_state == ST_SHIFT) ? next_s.transmit_shift_reg[0] : 1'b1;

    // Sticky events: a new event wins over a clear in the same cycle.
    next_s.irq_status = next_s.irq_status | events;
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);

    // Wake from sleep on the transmit flag; vector only with the global enable.
    next_s.wake = 1'b0;
    next_s.vector = 1'b0;
    if (s.sleep && transmit_irq_flag && s.peripheral_irq_enable && s.transmit_irq_enable) begin
      next_s.sleep = 1'b0;
      next_s.wake = 1'b1;
      next_s.vector = s.global_irq_enable;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      s.ahb_write_pend <= 1'b0;
      s.ahb_read_pend <= 1'b0;
      s.ahb_addr <= 8'h00;
      s.hrdata <= 32'h0000_0000;
      s.hreadyout <= 1'b1;
      {s.ninth_data_bit, s.transmitter_enable, s.nine_bit_transmit_enable,
       s.clock_source_master, s.sync_mode} <= RST_TX_CTRL;
      {s.continuous_receive_enable, s.single_receive_enable,
       s.serial_port_enable} <= RST_RX_CTRL;
      s.transmit_holding_reg <= 9'h000;
      s.holding_full <= 1'b0;
      s.transmit_shift_reg <= 9'h1ff;
      s.bit_cnt <= 4'h0;
      s.tx_state <= ST_IDLE;
      s.irq_status <= RST_IRQ;
      s.irq_mask <= RST_IRQ;
      s.irq <= 1'b0;
      {s.transmit_irq_enable, s.peripheral_irq_enable, s.global_irq_enable,
       s.sleep} <= RST_POWER;
      s.wake <= 1'b0;
      s.vector <= 1'b0;
      s.sck_meta <= 1'b0;
      s.sck_sync <= 1'b0;
      s.sck_prev <= 1'b0;
      s.dt_out <= 1'b1;
      s.dt_oe <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register; HRESP is tied to okay.
  assign HRDATA = s.hrdata;
  assign HREADYOUT = s.hreadyout;
  assign HRESP = 1'b0;
  assign SERIAL_DATA_OUT = s.dt_out;
  assign SERIAL_DATA_OE = s.dt_oe;
  assign IRQ = s.irq;
  assign WAKE = s.wake;
  assign VECTOR = s.vector;

endmodule

// ===== rtl/sync_tx_pkg.sv
// Constants shared by the synchronous slave transmitter: register map, fields, resets.
// Assumes a 32-bit AHB-Lite register bus and a word-aligned map.
package sync_tx_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_TX_CTRL = 8'h00;
  localparam logic [7:0] OFF_RX_CTRL = 8'h04;
  localparam logic [7:0] OFF_TX_HOLD = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_POWER = 8'h14;

  // Fields of transmit_control_reg.
  localparam int TXC_SYNC = 0;
  localparam int TXC_CLOCK_SOURCE_MASTER = 1;
  localparam int TXC_NINE_BIT = 2;
  localparam int TXC_TRANSMITTER_ENABLE = 3;
  localparam int TXC_NINTH_DATA_BIT = 4;
  localparam int TXC_SHIFT_EMPTY = 5;
  localparam int TXC_IRQ_FLAG = 6;

  // Fields of receive_control_reg.
  localparam int RXC_SERIAL_PORT_ENABLE = 0;
  localparam int RXC_SINGLE_RECEIVE = 1;
  localparam int RXC_CONTINUOUS_RECEIVE = 2;

  // Fields of the power control register.
  localparam int PWR_SLEEP = 0;
  localparam int PWR_GLOBAL_IRQ = 1;
  localparam int PWR_PERIPHERAL_IRQ = 2;
  localparam int PWR_TRANSMIT_IRQ = 3;

  // Sticky event bits in the status and mask registers.
  localparam int EVT_HOLD_EMPTIED = 0;
  localparam int EVT_SHIFT_DONE = 1;
  localparam int EVT_COUNT = 2;

  // Values after reset.
  localparam logic [4:0] RST_TX_CTRL = 5'h00;
  localparam logic [2:0] RST_RX_CTRL = 3'h0;
  localparam logic [3:0] RST_POWER = 4'h0;
  localparam logic [1:0] RST_IRQ = 2'h0;

  // Bit counts of one word.
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;

  // Shift engine states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } shift_state_t;

endpackage

// ===== testbench/sync_slave_tx_monitor.sv
// Port checker for the synchronous slave transmitter: bus timing, pin idle levels, wake pulses.
// Assumes it is bound to sync_slave_tx and sees only that module's ports.
`timescale 1ns/1ps
module sync_slave_tx_monitor (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // Register bus.
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Serial pins and events.
  input wire logic SERIAL_CLOCK_PIN,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_DATA_OE,
  input wire logic IRQ,
  input wire logic WAKE,
  input wire logic VECTOR
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  wire logic req = HSEL && HREADY && HTRANS[1];
  chk_write_no_wait: assert property (req && HWRITE |=> HREADYOUT)
    else $error("write answered with a wait state");
  chk_read_one_wait: assert property (req && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read not answered after one wait state");
  chk_resp_okay: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
  chk_reset_idle: assert property ($past(SYS_RST) |->
    HREADYOUT && SERIAL_DATA_OUT && !SERIAL_DATA_OE && !IRQ && !WAKE)
    else $error("outputs not idle after reset");
  chk_idle_high: assert property (!SERIAL_DATA_OE && !$past(SERIAL_DATA_OE) |-> SERIAL_DATA_OUT)
    else $error("data pin not idle while undriven");
  chk_bit_stable: assert property (SERIAL_CLOCK_PIN [*5] |-> $stable(SERIAL_DATA_OUT))
    else $error("data changed while shift clock high");
  chk_wake_single: assert property (WAKE |=> !WAKE)
    else $error("wake pulse longer than one cycle");
  chk_vector_wake: assert property (VECTOR |-> WAKE)
    else $error("vector without wake");
  cov_read: cover property (req && !HWRITE);
  cov_wake_vector: cover property (WAKE && VECTOR);
  cov_wake_only: cover property (WAKE && !VECTOR);
  cov_shift: cover property (SERIAL_DATA_OE && $fell(SERIAL_CLOCK_PIN));
endmodule

bind sync_slave_tx sync_slave_tx_monitor mon (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
  .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
  .SERIAL_DATA_OE(SERIAL_DATA_OE), .IRQ(IRQ), .WAKE(WAKE), .VECTOR(VECTOR));

// ===== testbench/ext_sync_master.sv
// External synchronous master: makes the shift clock per word and samples the data pin.
// Assumes the clock idles low between words and data is sampled on its rising edge.
`timescale 1ns/1ps
module ext_sync_master (
  // Device data pin.
  input wire logic dout,
  input wire logic oe,
  // Shift clock.
  output logic sclk
);
  logic last = 1'b0;
  wire logic pin = oe ? dout : ~last;
  initial sclk = 1'b0;
  // Gives one pulse per bit and collects the bits, first bit into bit 0.
  task automatic clock_word(input int n, output logic [8:0] word);
    word = '0;
    #1.3;
    for (int i = 0; i < n; i++) begin
      #24 sclk = 1'b1;
      word[i] = pin;
      last = pin;
      #24 sclk = 1'b0;
    end
  endtask
endmodule

// ===== testbench/tb.sv
// Testbench for the synchronous slave transmitter: registers, mode gating, shifting, sleep wake.
// Assumes the package sync_tx_pkg and the master model ext_sync_master.
`timescale 1ns/1ps
module tb;
  import sync_tx_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, sclk, dout, oe, irq, wake, vector;
  logic [8:0] word, w1, w2;
  int mismatches = 0;
  int num_checks = 0;
  int wakes = 0;
  int vectors = 0;
  int exp_q[$];
  logic [7:0] offs[5] = '{OFF_RX_CTRL, OFF_TX_HOLD, OFF_IRQ_MASK, OFF_POWER, 8'h20};
  logic [7:0] cfg[7] = '{8'h09, 8'h08, 8'h0b, 8'h09, 8'h09, 8'h09, 8'h01};
  logic [7:0] rxc[7] = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h05, 8'h00, 8'h01};

  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (wake === 1'b1) wakes++;
    if (vector === 1'b1) vectors++;
  end

  sync_slave_tx DUT (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .SERIAL_CLOCK_PIN(sclk),
    .SERIAL_DATA_OUT(dout), .SERIAL_DATA_OE(oe), .IRQ(irq), .WAKE(wake), .VECTOR(vector));
  ext_sync_master mst (.dout(dout), .oe(oe), .sclk(sclk));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  // Waits for the slave's answer; only the watchdog ends a hung wait.
  task automatic wait_ready();
    do begin
      @(posedge clk_sys);
    end while (hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string msg);
    bus(1'b0, a, '0);
    check(rd, exp, msg);
  endtask
  // Queues the expected word, ninth bit included, and writes its low byte.
  task automatic send(input logic [8:0] w);
    exp_q.push_back(int'(w));
    bus(1'b1, OFF_TX_HOLD, {24'h0, w[7:0]});
  endtask
  task automatic shift(input int n, input string msg);
    mst.clock_word(n, word);
    check({23'h0, word}, 32'(exp_q.pop_front()), msg);
    repeat (8) @(posedge clk_sys);
  endtask

  initial begin
    void'($urandom(32'h1167));
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd_check(OFF_TX_CTRL, 32'h20, "transmit control reset");
    foreach (offs[i]) rd_check(offs[i], 32'h0, "reset or unmapped value");
    foreach (cfg[i]) begin
      bus(1'b1, OFF_TX_CTRL, {24'h0, cfg[i]});
      bus(1'b1, OFF_RX_CTRL, {24'h0, rxc[i]});
      repeat (2) @(posedge clk_sys);
      check({31'h0, oe}, (i == 0) ? 32'h1 : 32'h0, "driver enable by mode");
    end
    bus(1'b1, OFF_TX_CTRL, 32'h09);
    repeat (2) @(posedge clk_sys);
    check({31'h0, oe}, 32'h1, "driver on in transmit mode");
    w1 = 9'($urandom_range(255));
    send(w1);
    shift(8, "eight bit word");
    rd_check(OFF_IRQ_STATUS, 32'h3, "events after word");
    bus(1'b1, OFF_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk_sys);
    check({31'h0, irq}, 32'h1, "unmasked event raises irq");
    bus(1'b1, OFF_IRQ_STATUS, 32'h3);
    repeat (2) @(posedge clk_sys);
    check({31'h0, irq}, 32'h0, "cleared event drops irq");
    bus(1'b1, OFF_TX_CTRL, 32'h1d);
    send(9'h100 | w1);
    shift(9, "nine bit word");
    bus(1'b1, OFF_TX_CTRL, 32'h09);
    w1 = 9'($urandom_range(255));
    w2 = 9'($urandom_range(255));
    bus(1'b1, OFF_POWER, 32'he);
    send(w1);
    send(w2);
    bus(1'b1, OFF_POWER, 32'hf);
    rd_check(OFF_TX_CTRL, 32'h09, "flag clear while first word shifts");
    check(wakes, 0, "no wake with second word held");
    shift(8, "first queued word");
    check(wakes, 1, "wake once second word loads");
    check(vectors, 1, "vector with global enable");
    rd_check(OFF_POWER, 32'he, "sleep cleared by wake");
    rd_check(OFF_TX_CTRL, 32'h49, "flag set after second load");
    shift(8, "second queued word");
    bus(1'b1, OFF_POWER, 32'hd);
    send(w1);
    repeat (4) @(posedge clk_sys);
    check(vectors, 1, "no vector without global enable");
    check(wakes, 2, "wake without global enable");
    shift(8, "word after wake");
    stop_test();
  end

  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
endmodule
